// ---- src/pors_pkg.sv ----
// Shared constants and types for the power-on reset sequencer.
// Assumes a single reference clock drives every flip-flop of the block.
package pors_pkg;

   // Counter width: enough for the longest release delay
   localparam int unsigned CNT_W        = 18;
   localparam int unsigned WORD_W       = 32;
   localparam int unsigned STRAP_W      = 17;
   localparam int unsigned SRC_W        = 3;
   localparam int unsigned RNG_W        = 2;
   localparam int unsigned SYNC_W       = 23;

   // Release delays in reference-clock cycles
   localparam int unsigned HR_STRAP_LO  = 15369;
   localparam int unsigned HR_STRAP_HI  = 34825;
   localparam int unsigned HR_I2C_R0    = 92545;
   localparam int unsigned HR_I2C_R1    = 107435;
   localparam int unsigned HR_I2C_R2    = 124208;
   localparam int unsigned HR_I2C_R3    = 157880;
   localparam logic [CNT_W-1:0] SR_DELAY = 18'h00010;
   localparam logic [CNT_W-1:0] POR_MIN  = 18'h00020;

   // Configuration source select encodings
   localparam logic [SRC_W-1:0] SRC_STRAP = 3'h0;
   localparam logic [SRC_W-1:0] SRC_HARD  = 3'h1;
   localparam logic [SRC_W-1:0] SRC_I2C   = 3'h2;

   // Clock range encodings: 0 below 44, 1 44-66, 2 66-100, 3 100-133 MHz
   localparam logic [RNG_W-1:0] RNG_HI_MIN = 2'h2;

   // Reset values of the sampled configuration and the stored word
   localparam logic [WORD_W-1:0] WORD_RST  = 32'h0000_0000;

   // Strap bundle sampled during power-on reset
   typedef struct packed {
      logic [SRC_W-1:0]   src;
      logic [STRAP_W-1:0] value;
      logic [RNG_W-1:0]   clkRange;
      logic               eepromLoad;
   } pors_cfg_s;

   localparam pors_cfg_s CFG_RST = '0;

   // One-hot sequencer states
   typedef enum logic [3:0] {
      ST_POR  = 4'h1,
      ST_HARD = 4'h2,
      ST_SOFT = 4'h4,
      ST_RUN  = 4'h8
   } pors_state_e;

endpackage

// ---- src/pors_sync.sv ----
// Three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk; output changes only once
// the second and third stages agree.
`timescale 1ns/1ps
module pors_sync
   import pors_pkg::*;
#(
   parameter int unsigned W               = 1,
   parameter logic [W-1:0] RST_VAL        = '0
)(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1R;
   logic [W-1:0] s2R;
   logic [W-1:0] s3R;
   logic [W-1:0] q_r;

   ////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second; the filter looks at stages 2 and 3
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1R <= RST_VAL;
         s2R <= RST_VAL;
         s3R <= RST_VAL;
         q_r <= RST_VAL;
      end
      else if (ce)
      begin
         s1R <= d;
         s2R <= s1R;
         s3R <= s2R;
         if (s2R == s3R)
            q_r <= s3R;  // Per-bit glitches are rejected as a whole word
      end
   end

   assign q = q_r;

endmodule

// ---- src/pors_seq.sv ----
// Power-on reset sequencer: strap sampling, config word source, and
// timed release of the open-drain hard and soft reset pins.
// Assumes clk is the reference clock and the board drives power_on_reset_n.
//
// Notes on behaviour
// RL1: Board holds power-on reset low at least 32 reference cycles.
// RL2: Config word comes from I2C EEPROM, strap pins, or built-in value.
// RL3: Sample 3-bit source select and 17-bit strap value during power-on reset.
// RL4: Board keeps clock-range strap valid through power-on and hard reset.
// RL5: EEPROM-load strap always valid; also latched during power-on reset.
// RL6: Strap/built-in: hard release after 15369 or 34825 cycles by clock range.
// RL7: I2C load: hard release after 92545/107435/124208/157880 cycles by range.
// RL8: Soft reset releases 16 cycles after hard reset releases.
// RL9: Soft reset held while hard reset held; both pins open-drain.
// RL10: Straps, source and word taken only on power-on reset. The code reads the live clock-range strap on a pin hard reset.
// RL11: One reference-clock counter; terminal count from source and range.
`timescale 1ns/1ps
module pors_seq
   import pors_pkg::*;
#(
   parameter int unsigned      HR_STRAP_LO_C = HR_STRAP_LO,
   parameter int unsigned      HR_STRAP_HI_C = HR_STRAP_HI,
   parameter int unsigned      HR_I2C_R0_C   = HR_I2C_R0,
   parameter int unsigned      HR_I2C_R1_C   = HR_I2C_R1,
   parameter int unsigned      HR_I2C_R2_C   = HR_I2C_R2,
   parameter int unsigned      HR_I2C_R3_C   = HR_I2C_R3,
   parameter logic [WORD_W-1:0] HARD_WORD    = 32'h0000_0000
)(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              power_on_reset_n,
   input  wire logic [SRC_W-1:0]  config_word_source_sel,
   input  wire logic [STRAP_W-1:0] config_strap_value,
   input  wire logic [RNG_W-1:0]  clock_range_strap,
   input  wire logic              eeprom_load_strap,
   input  wire logic              hardResetIn,
   output logic                   hardResetOut,
   output logic                   hardResetOe,
   input  wire logic              softResetIn,
   output logic                   softResetOut,
   output logic                   softResetOe,
   output logic                   i2cLoadReq,
   input  wire logic [WORD_W-1:0] i2cWord,
   input  wire logic              i2cWordValid,
   output logic [WORD_W-1:0]      startup_config_word,
   output logic                   configValid,
   output pors_cfg_s              sampledCfg,
   output logic                   porTooShort,
   output logic                   extSoftReset
);

   pors_cfg_s       strapSync;
   logic [2:0]      pinSync;
   logic            porLow;
   pors_state_e     state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] term_r;
   logic [CNT_W-1:0] porCnt_r;
   pors_cfg_s       cfg_r;
   logic [WORD_W-1:0] word_r;
   logic            wordValid_r;
   logic            tooShort_r;
   logic            extHard_r;
   logic [CNT_W-1:0] hwCnt;

   // Terminal count from source and clock range
   function automatic logic [CNT_W-1:0] termSel(input logic [SRC_W-1:0] s,
                                                input logic [RNG_W-1:0] r);
      logic [CNT_W-1:0] t;
      t = CNT_W'(HR_STRAP_LO_C);
      if (s == SRC_I2C)
      begin
         case (r)
            2'h0:    t = CNT_W'(HR_I2C_R0_C);
            2'h1:    t = CNT_W'(HR_I2C_R1_C);
            2'h2:    t = CNT_W'(HR_I2C_R2_C);
            default: t = CNT_W'(HR_I2C_R3_C);
         endcase
      end
      else if (r >= RNG_HI_MIN)
         t = CNT_W'(HR_STRAP_HI_C);
      return t;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; reset pins start as asserted / released
   pors_sync #(.W(SYNC_W), .RST_VAL('0)) uStrapSync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .d     ({config_word_source_sel, config_strap_value,
               clock_range_strap, eeprom_load_strap}),
      .q     (strapSync)
   );

   pors_sync #(.W(3), .RST_VAL(3'h6)) uPinSync
   (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .d     ({hardResetIn, softResetIn, power_on_reset_n}),
      .q     (pinSync)
   );

   assign porLow = !pinSync[0];

   ////////////////////////////////////////////////////////////////////////
   // Sequencer state and the single delay counter
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r <= ST_POR;
         cnt_r   <= '0;
         term_r  <= '0;
      end
      else if (ce)
      begin
         if (porLow)
         begin
            state_r <= ST_POR;  // Power-on reset restarts from any state
            cnt_r   <= '0;
         end
         else
         begin
            case (state_r)
               ST_POR:
               begin
                  state_r <= ST_HARD;
                  cnt_r   <= '0;
                  term_r  <= termSel(cfg_r.src, cfg_r.clkRange); // RL6 RL7 RL11
               end
               ST_HARD:
               begin
                  if (cnt_r == term_r - 1'b1) // RL11
                  begin
                     state_r <= ST_SOFT;
                     cnt_r   <= '0;
                  end
                  else
                     cnt_r <= cnt_r + 1'b1;
               end
               ST_SOFT:
               begin
                  if (cnt_r == SR_DELAY - 1'b1) // RL8
                     state_r <= ST_RUN;
                  cnt_r <= cnt_r + 1'b1;
               end
               ST_RUN:
               begin
                  // External hard reset reruns the strap timing at the live clock-range strap;
                  // only watched here so our own release edge is not seen
                  if (!pinSync[2])
                  begin
                     state_r <= ST_HARD;
                     cnt_r   <= '0;
                     term_r  <= termSel(SRC_STRAP, strapSync.clkRange); // RL10
                  end
               end
               default:
               begin
                  state_r <= ST_POR;
                  cnt_r   <= '0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Strap capture: only while power-on reset is held low
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cfg_r <= CFG_RST;
      else if (ce && porLow)
         cfg_r <= strapSync;  // RL3 RL5 RL10
   end

   ////////////////////////////////////////////////////////////////////////
   // Config word: built from the chosen source, written once per power-on
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         word_r      <= WORD_RST;
         wordValid_r <= 1'b0;
      end
      else if (ce)
      begin
         if (porLow)
         begin
            word_r      <= WORD_RST;
            wordValid_r <= 1'b0;
         end
         else if (state_r == ST_POR)
         begin
            // RL2
            if (cfg_r.src == SRC_STRAP)
            begin
               word_r      <= WORD_W'(cfg_r.value);
               wordValid_r <= 1'b1;
            end
            else if (cfg_r.src != SRC_I2C)
            begin
               word_r      <= HARD_WORD;  // Unused encodings use built-in
               wordValid_r <= 1'b1;
            end
         end
         else if (i2cLoadReq && i2cWordValid)
         begin
            word_r      <= i2cWord;  // RL2
            wordValid_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Marks a hard phase rerun by the board pin; only power-on clears it
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         extHard_r <= 1'b0;
      else if (ce)
      begin
         if (porLow)
            extHard_r <= 1'b0;
         else if ((state_r == ST_RUN) && !pinSync[2])
            extHard_r <= 1'b1;
      end
   end

   // Request runs only in the first hard phase after power-on reset
   assign i2cLoadReq = (state_r == ST_HARD) && (cfg_r.src == SRC_I2C)
                       && !wordValid_r && !extHard_r; // RL10

   ////////////////////////////////////////////////////////////////////////
   // Power-on pulse width check; a short pulse is only flagged
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         porCnt_r   <= '0;
         tooShort_r <= 1'b0;
      end
      else if (ce)
      begin
         if (porLow)
         begin
            if (porCnt_r != POR_MIN)
               porCnt_r <= porCnt_r + 1'b1;
         end
         else
         begin
            porCnt_r <= '0;
            if (state_r == ST_POR)
               tooShort_r <= (porCnt_r != POR_MIN); // RL1
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Open-drain pins: drive low while asserting, soft covers hard
   assign hardResetOut = 1'b0;
   assign softResetOut = 1'b0;
   assign hardResetOe  = (state_r == ST_POR) || (state_r == ST_HARD);
   assign softResetOe  = hardResetOe || (state_r == ST_SOFT); // RL9

   assign startup_config_word = word_r;
   assign configValid         = wordValid_r;
   assign sampledCfg          = cfg_r;
   assign porTooShort         = tooShort_r;
   assign extSoftReset        = (state_r == ST_RUN) && !pinSync[1];

   ////////////////////////////////////////////////////////////////////////
   // Helper: cycles spent in the hard phase, for the checks below
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         hwCnt <= '0;
      else if (ce)
         hwCnt <= (state_r == ST_HARD) ? hwCnt + 1'b1 : '0;
   end

   a_soft_covers_hard: assert property ( // RL9
      @(posedge clk) disable iff (!rst_n)
      hardResetOe |-> softResetOe)
      else $error("soft reset released while hard reset held");

   a_soft_release_gap: assert property ( // RL8
      @(posedge clk) disable iff (!rst_n || !ce)
      $fell(hardResetOe) |-> ##15 softResetOe ##1 !softResetOe)
      else $error("soft reset not released 16 cycles after hard");

   a_hard_strap_time: assert property ( // RL6
      @(posedge clk) disable iff (!rst_n || !ce)
      $fell(hardResetOe) && (cfg_r.src != SRC_I2C) && !extHard_r
      |-> hwCnt == ((cfg_r.clkRange >= RNG_HI_MIN) ?
                    CNT_W'(HR_STRAP_HI_C) : CNT_W'(HR_STRAP_LO_C)))
      else $error("strap path hard release at wrong count");

   a_hard_i2c_time: assert property ( // RL7
      @(posedge clk) disable iff (!rst_n || !ce)
      $fell(hardResetOe) && (cfg_r.src == SRC_I2C) && configValid
      && !extHard_r
      |-> hwCnt == termSel(SRC_I2C, cfg_r.clkRange))
      else $error("I2C path hard release at wrong count");

   a_hard_ext_time: assert property ( // RL10
      @(posedge clk) disable iff (!rst_n || !ce)
      $fell(hardResetOe) && extHard_r
      |-> hwCnt == termSel(SRC_STRAP, strapSync.clkRange))
      else $error("pin hard reset released at wrong count");

   a_cfg_sample_por: assert property ( // RL3
      @(posedge clk) disable iff (!rst_n)
      ce && porLow |=> cfg_r == $past(strapSync))
      else $error("straps not captured during power-on reset");

   a_cfg_hold_run: assert property ( // RL10
      @(posedge clk) disable iff (!rst_n)
      !porLow && $past(!porLow) |-> $stable(cfg_r))
      else $error("configuration changed outside power-on reset");

   a_word_strap_src: assert property ( // RL2
      @(posedge clk) disable iff (!rst_n)
      configValid && (cfg_r.src == SRC_STRAP)
      |-> startup_config_word == WORD_W'(cfg_r.value))
      else $error("strap-sourced word differs from sampled straps");

   a_eeprom_latched: assert property ( // RL5
      @(posedge clk) disable iff (!rst_n)
      i2cLoadReq |-> (sampledCfg.eepromLoad == strapSync.eepromLoad)
                     && $stable(sampledCfg.eepromLoad))
      else $error("EEPROM strap moved during load");

   a_count_bounded: assert property ( // RL11
      @(posedge clk) disable iff (!rst_n)
      (state_r == ST_HARD) |-> (cnt_r < term_r) && (hwCnt == cnt_r))
      else $error("delay counter passed its terminal count");

endmodule

// ---- bench/pors_board.sv ----
// Board model: power-on reset source, pulled-up open-drain reset pins
// and an EEPROM reader that answers load requests.
// Assumes the bench drives its controls by NBA at the falling edge.
`timescale 1ns/1ps
module pors_board
   import pors_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              porGo,
   input  wire logic [7:0]        porLen,
   input  wire logic              hardPull,
   input  wire logic              softPull,
   input  wire logic              eepOn,
   input  wire logic [WORD_W-1:0] eepWord,
   input  wire logic              hardResetOut,
   input  wire logic              hardResetOe,
   input  wire logic              softResetOut,
   input  wire logic              softResetOe,
   input  wire logic              i2cLoadReq,
   output logic                   power_on_reset_n,
   output logic                   hardResetIn,
   output logic                   softResetIn,
   output logic [WORD_W-1:0]      i2cWord,
   output logic                   i2cWordValid
);
   logic [7:0]        porCnt = 8'h00;
   logic [3:0]        eepDly = 4'h0;
   logic [WORD_W-1:0] lastW  = '0;

   initial
   begin
      power_on_reset_n = 1'b0;
      i2cWordValid = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   // Power-on held low porLen cycles; supplies good from time zero
   always @(negedge clk)
   begin
      if (porGo)
      begin
         porCnt <= porLen;
         power_on_reset_n <= 1'b0;
      end
      else if (porCnt > 8'h01)
         porCnt <= porCnt - 8'h01;
      else if (porCnt == 8'h01)
      begin
         porCnt <= 8'h00;
         power_on_reset_n <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Pull-ups win unless some party pulls the pin low
   assign hardResetIn = !(hardResetOe && !hardResetOut) && !hardPull;
   assign softResetIn = !(softResetOe && !softResetOut) && !softPull;
   ////////////////////////////////////////////////////////////////////
   // Word four cycles after a request; idle lines show the inverse
   // so a stale word can never pass for a fresh one
   always @(negedge clk)
   begin
      i2cWordValid <= 1'b0;
      if (i2cLoadReq && eepOn && !i2cWordValid)
      begin
         eepDly <= eepDly + 4'h1;
         if (eepDly == 4'h3)
         begin
            i2cWordValid <= 1'b1;
            lastW <= eepWord;
         end
      end
      else
         eepDly <= 4'h0;
   end
   assign i2cWord = i2cWordValid ? lastW : ~lastW;
endmodule

// ---- bench/pors_seq_test.sv ----
// Bench for the reset sequencer: all sources and ranges, short pulse,
// missing EEPROM word, external hard and soft pin activity.
// Assumes shortened release counts handed in as parameters.
`timescale 1ns/1ps
module pors_seq_test;
   import pors_pkg::*;
   localparam int unsigned       T_SL = 40;
   localparam int unsigned       T_SH = 60;
   localparam logic [WORD_W-1:0] HW   = 32'hA5C3_0F1E;
   localparam logic [WORD_W-1:0] EW   = 32'h3C96_D24B;

   logic               clk = 1'b0, rst_n = 1'b0;
   logic [SRC_W-1:0]   sel = SRC_STRAP;
   logic [STRAP_W-1:0] val = '0;
   logic [RNG_W-1:0]   rng = '0;
   logic               eep = 1'b0, porGo = 1'b0, eepOn = 1'b1;
   logic               hardPull = 1'b0, softPull = 1'b0;
   logic [7:0]         porLen = 8'h28;
   logic               porN, hIn, hOut, hOe, sIn, sOut, sOe, lReq, wVal;
   logic               cfgValid, tooShort, extSoft;
   logic [WORD_W-1:0]  i2cW, word, expWord;
   pors_cfg_s          cfgOut, expCfg;
   int                 fails = 0, compares = 0, cycles = 0;

   always #2 clk = ~clk;

   pors_seq #(.HR_STRAP_LO_C(T_SL), .HR_STRAP_HI_C(T_SH),
      .HR_I2C_R0_C(80), .HR_I2C_R1_C(90), .HR_I2C_R2_C(100),
      .HR_I2C_R3_C(110), .HARD_WORD(HW)) dut_u (
      .clk(clk), .rst_n(rst_n), .ce(1'b1), .power_on_reset_n(porN),
      .config_word_source_sel(sel), .config_strap_value(val),
      .clock_range_strap(rng), .eeprom_load_strap(eep),
      .hardResetIn(hIn), .hardResetOut(hOut), .hardResetOe(hOe),
      .softResetIn(sIn), .softResetOut(sOut), .softResetOe(sOe),
      .i2cLoadReq(lReq), .i2cWord(i2cW), .i2cWordValid(wVal),
      .startup_config_word(word), .configValid(cfgValid),
      .sampledCfg(cfgOut), .porTooShort(tooShort),
      .extSoftReset(extSoft));

   pors_board board_u (.clk(clk), .porGo(porGo), .porLen(porLen),
      .hardPull(hardPull), .softPull(softPull), .eepOn(eepOn),
      .eepWord(EW), .hardResetOut(hOut), .hardResetOe(hOe),
      .softResetOut(sOut), .softResetOe(sOe), .i2cLoadReq(lReq),
      .power_on_reset_n(porN), .hardResetIn(hIn), .softResetIn(sIn),
      .i2cWord(i2cW), .i2cWordValid(wVal));
   ////////////////////////////////////////////////////////////////////
   // Verdict and hang guard; a run takes a few thousand cycles
   task automatic report_and_stop();
      $display("Compares %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         fails++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Compare tasks, one for each kind of result
   task automatic chk_bit(input logic got, input logic exp, input string m);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t: %s got %b", $time, m, got);
      end
   endtask

   task automatic chk_word(input logic [WORD_W-1:0] got,
                           input logic [WORD_W-1:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t: word got %h", $time, got);
      end
   endtask

   task automatic chk_cfg(input pors_cfg_s got, input pors_cfg_s exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t: straps got %h", $time, got);
      end
   endtask

   task automatic chk_cnt(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi)
      begin
         fails++;
         $display("ERROR %0t: count %0d", $time, got);
      end
   endtask

   function automatic int exp_delay(input logic [SRC_W-1:0] s,
                                    input logic [RNG_W-1:0] r);
      if (s == SRC_I2C)
         return 80 + 10 * int'(r);
      return r >= RNG_HI_MIN ? T_SH : T_SL;
   endfunction
   ////////////////////////////////////////////////////////////////////
   // Counts edges to hard release, then to soft release; moves the
   // source straps mid-sequence, which must not be taken
   task automatic measure(input int t, input int n0);
      int   n, g;
      logic bad;
      n = n0;
      g = 0;
      bad = 1'b0;
      while ((n < 8 || hOe === 1'b1) && n < 400)
      begin
         @(posedge clk);
         #1;
         n++;
         if (hOe === 1'b1 && sOe !== 1'b1)
            bad = 1'b1;
      end
      @(negedge clk);
      hardPull <= 1'b0;
      sel = ~sel;
      val = ~val;
      while (sOe === 1'b1 && g < 40)
      begin
         @(posedge clk);
         #1;
         g++;
      end
      chk_cnt(n, t + 4, t + 5);
      chk_cnt(g, 16, 16);
      chk_bit(bad, 1'b0, "soft held");
      chk_cfg(cfgOut, expCfg);
   endtask

   task automatic run_seq(input logic [SRC_W-1:0] s,
      input logic [RNG_W-1:0] r, input logic [7:0] len, input logic on);
      expCfg = '{s, {r, s, 12'hB5C}, r, r[0]};
      expWord = s == SRC_I2C ? EW
              : s == SRC_STRAP ? WORD_W'(expCfg.value) : HW;
      sel = s;
      val = expCfg.value;
      rng = r;
      eep = r[0];
      eepOn <= on;
      porLen <= len;
      porGo <= 1'b1;
      @(negedge clk);
      porGo <= 1'b0;
      do
      begin
         @(posedge clk);
         #1;
      end
      while (porN !== 1'b1);
      measure(exp_delay(s, r), 1);
      chk_bit(cfgValid, on || s != SRC_I2C, "valid");
      if (on || s != SRC_I2C)
         chk_word(word, expWord);
      chk_bit(tooShort, len < 8'h20, "short");
   endtask
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      chk_bit(hOe & sOe, 1'b1, "reset pins");
      chk_cfg(cfgOut, CFG_RST);
      for (int s = 1; s < 8; s++)
         run_seq(SRC_W'(s == 2 ? 1 : s), RNG_W'(s), 8'h28, 1'b1);
      for (int r = 0; r < 4; r++)
         run_seq(SRC_I2C, RNG_W'(r), 8'h28, 1'b1);
      run_seq(SRC_I2C, 2'h1, 8'h28, 1'b0);
      run_seq(SRC_STRAP, 2'h1, 8'h14, 1'b1);
      for (int r = 0; r < 4; r++)
         run_seq(SRC_STRAP, RNG_W'(r), 8'h20, 1'b1);
      // Hard pin pulled in run: live range gives the strap count
      @(negedge clk);
      rng = 2'h0;
      hardPull <= 1'b1;
      measure(T_SL, 0);
      chk_word(word, expWord);
      softPull <= 1'b1;
      repeat (6) @(negedge clk);
      chk_bit(extSoft, 1'b1, "soft seen");
      chk_bit(hOe, 1'b0, "hard left");
      softPull <= 1'b0;
      repeat (6) @(negedge clk);
      chk_bit(extSoft, 1'b0, "soft idle");
      report_and_stop();
   end
endmodule
